// File: src/sysclk_source_prescaler.sv
// system clock source selection, prescaler and glitch-free switching
//
// Overview of operation
// [R1] select code 11 drives from direct input
// [R2] direct mode copies input frequency and duty
// [R3] code 10 with bypass set: prescaler mode
// [R4] prescaler divides crystal or internal oscillator
// [R5] prescaler factor is divider field plus one
// [R6] factor one passes oscillator with its duty
// [R7] largest factor divides oscillator by 1024
// [R8] crystal bypass at factor one equals direct
// [R9] device inserts programmed flash wait states
// [R10] device adds programmed wait extension cycles
// [R11] full wait penalty only on non-sequential accesses; code also applies it to sequential accesses that miss the prefetch address
// [R12] prefetch ahead hides waits on sequential streams
// [R13] code 10 with bypass clear: loop output
// [R14] code 00 selects the wakeup oscillator
// [R15] source or divider change makes no runts
`timescale 1ns/1ps
module sysclk_source_prescaler
  import sysclk_pkg::*;
#(
  parameter int DIV_W  = DIV_FIELD_W,
  parameter int ADDR_W = ADDR_W_DEF
)(
  input  wire logic              ref_clk,
  input  wire logic              reset_n,
  input  wire logic              direct_clock_input,
  input  wire logic              crystal_input,
  input  wire logic              internal_osc_input,
  input  wire logic              loop_clock_input,
  input  wire logic              wakeup_osc_input,
  input  wire logic [1:0]        clock_source_select,
  input  wire logic              oscillator_bypass,
  input  wire logic              prescaler_source_select,
  input  wire logic [DIV_W-1:0]  prescaler_divider_field,
  input  wire logic [WS_W-1:0]   flash_wait_state_count,
  input  wire logic [EXT_W-1:0]  flash_wait_extension,
  input  wire logic              access_req,
  input  wire logic              access_seq,
  input  wire logic [ADDR_W-1:0] access_addr,
  output logic                   sys_clock,
  output logic                   sys_tick,
  output sysclk_pkg::mode_type   active_mode,
  output logic                   switch_busy,
  output logic                   access_busy,
  output logic                   access_done,
  output logic                   prefetch_hit
);
  import sysclk_pkg::*;

  if (DIV_W < 1 || DIV_W > 16 || (2 ** DIV_W) > 65536)
  begin : g_chk
    $error("sysclk_source_prescaler: DIV_W out of range");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    switch_state_type   st;
    logic [NUM_SRC-1:0] sync1;
    logic [NUM_SRC-1:0] sync2;
    logic [NUM_SRC-1:0] sync3;
    mode_type           act_mode;
    logic [DIV_W-1:0]   act_div;
    logic               act_osc;
    logic [DIV_W-1:0]   div_cnt;
    logic               clk_out;
    logic               tick;
    logic               busy;
  } clk_reg_type;

  clk_reg_type        state_reg;
  clk_reg_type        state_next;
  logic [NUM_SRC-1:0] src_in;
  int                 idx;
  logic               lvl;
  logic               rise;
  logic               change;
  logic               new_lvl;
  logic               passthru;
  logic               run_out;
  logic [DIV_W-1:0]   run_cnt;
  mode_type           want_mode;

  assign src_in = {wakeup_osc_input, loop_clock_input, internal_osc_input,
                   crystal_input, direct_clock_input};

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic mode_type next_mode(logic [1:0] sel, logic byp, mode_type cur);
    case (sel)
      SEL_DIRECT:   return MODE_DIRECT;
      SEL_PRESCALE: return byp ? MODE_PRESCALE : MODE_LOOP;
      SEL_WAKEUP:   return MODE_WAKEUP;
      // reserved code keeps the running mode; in prescale mode a changed divider or oscillator select still starts a switch
      default:      return cur;
    endcase
  endfunction

  function automatic int src_index(mode_type m, logic osc);
    case (m)
      MODE_DIRECT:   return SRC_DIRECT;
      MODE_LOOP:     return SRC_LOOP;
      MODE_PRESCALE: return osc ? SRC_INTERNAL : SRC_CRYSTAL;
      default:       return SRC_WAKEUP;
    endcase
  endfunction

  // source periods spent high: ceil((div+1)/2)
  function automatic logic [DIV_W-1:0] high_count(logic [DIV_W-1:0] div);
    logic [DIV_W:0] sum;
    sum = ({1'b0, div} + (DIV_W+1)'(2)) >> 1;
    return sum[DIV_W-1:0];
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    state_next       = state_reg;
    // the first stage feeds only the second; edges are taken on stages two and three
    state_next.sync1 = src_in;
    state_next.sync2 = state_reg.sync1;
    state_next.sync3 = state_reg.sync2;

    idx  = src_index(state_reg.act_mode, state_reg.act_osc); // R1 R4 R13 R14
    lvl  = state_reg.sync2[idx];
    rise = lvl & ~state_reg.sync3[idx];

    want_mode = next_mode(clock_source_select, oscillator_bypass, state_reg.act_mode); // R3 R13 R14
    new_lvl   = state_reg.sync2[src_index(want_mode, prescaler_source_select)]; // R15
    change    = (want_mode != state_reg.act_mode)
             || (want_mode == MODE_PRESCALE
                 && (prescaler_divider_field != state_reg.act_div
                     || prescaler_source_select != state_reg.act_osc));

    // factor one and non-prescaled sources keep the source's own duty cycle
    passthru = (state_reg.act_mode != MODE_PRESCALE) || (state_reg.act_div == '0); // R2 R6 R8
    run_out  = state_reg.clk_out;
    run_cnt  = state_reg.div_cnt;
    if (passthru)
      run_out = lvl; // R2 R6 R8
    else if (rise)
    begin
      run_cnt = (state_reg.div_cnt == state_reg.act_div) ? '0
              : DIV_W'(state_reg.div_cnt + DIV_W'(1)); // R5 R7
      run_out = run_cnt < high_count(state_reg.act_div); // R5
    end

    case (state_reg.st)
      ST_RUN:
      begin
        state_next.clk_out = run_out;
        state_next.div_cnt = run_cnt;
        if (change)
          state_next.st = ST_DRAIN;
      end
      ST_DRAIN:
      begin
        // finish the running high phase; a low phase may only grow
        if (state_reg.clk_out)
        begin
          state_next.clk_out = run_out;
          state_next.div_cnt = run_cnt;
        end
        // load only while the new source is high, so a whole low phase of it passes
        else if (new_lvl)
        begin
          state_next.act_mode = want_mode; // R15
          state_next.act_div  = prescaler_divider_field;
          state_next.act_osc  = prescaler_source_select;
          state_next.div_cnt  = '0;
          state_next.st       = ST_ARM;
        end
      end
      ST_ARM:
      begin
        // hold low until the new source gives a full rising edge
        if (rise)
        begin
          state_next.clk_out = 1'b1; // R15
          state_next.div_cnt = '0;
          state_next.st      = ST_RUN;
        end
      end
      default:
      begin
        state_next.clk_out = 1'b0;
        state_next.st      = ST_DRAIN;
      end
    endcase

    state_next.tick = state_next.clk_out & ~state_reg.clk_out;
    state_next.busy = (state_next.st != ST_RUN);
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_reg          <= '0;
      state_reg.st       <= ST_DRAIN;
      state_reg.act_mode <= MODE_WAKEUP;
      state_reg.busy     <= 1'b1;
    end
    else
      state_reg <= state_next;
  end

  assign sys_clock   = state_reg.clk_out;
  assign sys_tick    = state_reg.tick;
  assign active_mode = state_reg.act_mode;
  assign switch_busy = state_reg.busy;

  // ----------------------------------------------------------------
  // flash timing, paced by system clock ticks
  // ----------------------------------------------------------------
  flash_wait_control #(
    .ADDR_W (ADDR_W)
  ) u_flash (
    .ref_clk                (ref_clk),
    .reset_n                (reset_n),
    .sys_tick               (state_reg.tick),
    .flash_wait_state_count (flash_wait_state_count),
    .flash_wait_extension   (flash_wait_extension),
    .access_req             (access_req),
    .access_seq             (access_seq),
    .access_addr            (access_addr),
    .access_busy            (access_busy),
    .access_done            (access_done),
    .prefetch_hit           (prefetch_hit)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  chk_direct_follow: assert property ( // R1 R2
    state_reg.st == ST_RUN && state_reg.act_mode == MODE_DIRECT
    |=> sys_clock == $past(state_reg.sync2[SRC_DIRECT]))
    else $error("direct mode output does not follow direct input");

  chk_unity_follow: assert property ( // R4 R6 R8
    state_reg.st == ST_RUN && state_reg.act_mode == MODE_PRESCALE && state_reg.act_div == '0
    |=> sys_clock == $past(state_reg.act_osc ? state_reg.sync2[SRC_INTERNAL]
                                             : state_reg.sync2[SRC_CRYSTAL]))
    else $error("factor one output does not follow oscillator");

  chk_period_start: assert property ( // R5
    state_reg.st == ST_RUN && !passthru && rise && state_reg.div_cnt == state_reg.act_div
    |=> $rose(sys_clock) ##0 state_reg.div_cnt == '0)
    else $error("divided period did not restart after factor edges");

  chk_low_phase: assert property ( // R5 R7
    state_reg.st == ST_RUN && !passthru && rise
    && (DIV_W+1)'(state_reg.div_cnt) + (DIV_W+1)'(1) == (DIV_W+1)'(high_count(state_reg.act_div))
    |=> $fell(sys_clock))
    else $error("divided clock high phase has wrong length");

  chk_arm_low: assert property ( // R15
    state_reg.st == ST_ARM |-> !sys_clock && switch_busy)
    else $error("clock not held low while arming new source");

  chk_drain_hold: assert property ( // R15
    state_reg.st == ST_DRAIN && sys_clock
    |=> state_reg.act_mode == $past(state_reg.act_mode)
        && state_reg.act_div == $past(state_reg.act_div))
    else $error("source switched during a high phase");

  chk_mode_load: assert property ( // R3 R13 R14
    state_reg.st == ST_DRAIN && !sys_clock && new_lvl
    |=> state_reg.st == ST_ARM && active_mode == $past(want_mode))
    else $error("selected source not loaded at switch");

  chk_drain_wait: assert property ( // R15
    state_reg.st == ST_DRAIN && !sys_clock && !new_lvl
    |=> state_reg.st == ST_DRAIN && !sys_clock)
    else $error("switch did not wait for the new source to be high");

  chk_loop_follow: assert property ( // R13
    state_reg.st == ST_RUN && state_reg.act_mode == MODE_LOOP
    |=> sys_clock == $past(state_reg.sync2[SRC_LOOP]))
    else $error("loop mode output does not follow loop clock");

  chk_wakeup_follow: assert property ( // R14
    state_reg.st == ST_RUN && state_reg.act_mode == MODE_WAKEUP
    |=> sys_clock == $past(state_reg.sync2[SRC_WAKEUP]))
    else $error("wakeup mode output does not follow wakeup oscillator");

  chk_tick_edge: assert property (sys_tick == $rose(sys_clock)) // R9 R10
    else $error("system tick does not mark a rising system clock");

  chk_reserved_keep: assert property ( // R15
    state_reg.st == ST_RUN && clock_source_select == SEL_RESERVED && active_mode != MODE_PRESCALE
    |=> state_reg.st == ST_RUN)
    else $error("reserved select started a switch");

  cov_direct_run: cover property (state_reg.st == ST_RUN && active_mode == MODE_DIRECT
                                  ##1 $rose(sys_clock));
  cov_max_factor: cover property (state_reg.st == ST_RUN && active_mode == MODE_PRESCALE
                                  && (&state_reg.act_div) && $rose(sys_clock));
  cov_switch_done: cover property (state_reg.st == ST_ARM ##[1:1000] state_reg.st == ST_RUN);

endmodule

// File: src/sysclk_pkg.sv
// shared constants and types for the system clock source and flash wait logic
package sysclk_pkg;

  // ----------------------------------------------------------------
  // clocking and divider
  // ----------------------------------------------------------------
  localparam int REF_CLK_MHZ  = 250;
  localparam int DIV_FIELD_W  = 10;
  localparam int MAX_PRESCALE = 1024;

  // clock source select codes
  localparam logic [1:0] SEL_WAKEUP   = 2'h0;
  localparam logic [1:0] SEL_RESERVED = 2'h1;
  localparam logic [1:0] SEL_PRESCALE = 2'h2;
  localparam logic [1:0] SEL_DIRECT   = 2'h3;

  // bit positions in the synchronised source vector
  localparam int SRC_DIRECT   = 0;
  localparam int SRC_CRYSTAL  = 1;
  localparam int SRC_INTERNAL = 2;
  localparam int SRC_LOOP     = 3;
  localparam int SRC_WAKEUP   = 4;
  localparam int NUM_SRC      = 5;

  // ----------------------------------------------------------------
  // flash wait states
  // ----------------------------------------------------------------
  localparam int WS_W       = 4;
  localparam int EXT_W      = 2;
  localparam int CNT_W      = 5;
  localparam int ADDR_W_DEF = 20;
  localparam int WS_LIMIT1_MHZ = 8;
  localparam int WS_LIMIT2_MHZ = 13;
  localparam int WS_LIMIT3_MHZ = 17;
  localparam int EXT_LIMIT_MHZ = 80;

  // least wait-state setting software must program for a system clock
  function automatic int min_wait_states(int mhz);
    if (mhz <= WS_LIMIT1_MHZ) return 1;
    if (mhz <= WS_LIMIT2_MHZ) return 2;
    if (mhz <= WS_LIMIT3_MHZ) return 3;
    return 4;
  endfunction

  function automatic int min_wait_extension(int mhz);
    return (mhz > EXT_LIMIT_MHZ) ? 1 : 0;
  endfunction

  typedef enum logic [3:0] {
    MODE_WAKEUP   = 4'h1,
    MODE_LOOP     = 4'h2,
    MODE_PRESCALE = 4'h4,
    MODE_DIRECT   = 4'h8
  } mode_type;

  typedef enum logic [2:0] {
    ST_RUN   = 3'h1,
    ST_DRAIN = 3'h2,
    ST_ARM   = 3'h4
  } switch_state_type;

  typedef enum logic [1:0] {
    F_IDLE = 2'h1,
    F_WAIT = 2'h2
  } flash_state_type;

endpackage

// File: src/flash_wait_control.sv
// flash access timing with programmable wait states and sequential prefetch
`timescale 1ns/1ps
module flash_wait_control
  import sysclk_pkg::*;
#(
  parameter int ADDR_W = ADDR_W_DEF
)(
  input  wire logic              ref_clk,
  input  wire logic              reset_n,
  input  wire logic              sys_tick,
  input  wire logic [WS_W-1:0]   flash_wait_state_count,
  input  wire logic [EXT_W-1:0]  flash_wait_extension,
  input  wire logic              access_req,
  input  wire logic              access_seq,
  input  wire logic [ADDR_W-1:0] access_addr,
  output logic                   access_busy,
  output logic                   access_done,
  output logic                   prefetch_hit
);
  import sysclk_pkg::*;

  if (ADDR_W < 2 || ADDR_W > 32)
  begin : g_chk
    $error("flash_wait_control: ADDR_W out of range");
  end

  typedef struct packed {
    flash_state_type   fst;
    logic [CNT_W-1:0]  cnt;
    logic [ADDR_W-1:0] addr;
    logic [ADDR_W-1:0] pf_addr;
    logic [CNT_W-1:0]  pf_left;
    logic              pf_valid;
    logic              busy;
    logic              done;
    logic              hit;
  } flash_reg_type;

  flash_reg_type    state_reg;
  flash_reg_type    state_next;
  logic [CNT_W-1:0] penalty;
  logic             seq_hit;

  function automatic logic [CNT_W-1:0] wait_total(logic [WS_W-1:0] ws, logic [EXT_W-1:0] ext);
    return CNT_W'(ws) + CNT_W'(ext);
  endfunction

  always_comb
  begin
    state_next      = state_reg;
    state_next.done = 1'b0;
    penalty         = wait_total(flash_wait_state_count, flash_wait_extension); // R9 R10
    seq_hit         = access_seq && state_reg.pf_valid && (access_addr == state_reg.pf_addr);
    case (state_reg.fst)
      F_IDLE:
      begin
        // prefetch of the next word keeps running while the bus is idle
        if (sys_tick && state_reg.pf_left != '0)
          state_next.pf_left = state_reg.pf_left - CNT_W'(1); // R12
        if (access_req)
        begin
          state_next.addr = access_addr;
          state_next.hit  = seq_hit;
          state_next.fst  = F_WAIT;
          state_next.busy = 1'b1;
          if (seq_hit)
            state_next.cnt = state_next.pf_left + CNT_W'(1); // R11 R12
          else
          begin
            state_next.cnt      = penalty + CNT_W'(1); // R11
            state_next.pf_valid = 1'b0;
          end
        end
      end
      F_WAIT:
      begin
        if (sys_tick)
        begin
          state_next.cnt = state_reg.cnt - CNT_W'(1);
          if (state_reg.cnt == CNT_W'(1))
          begin
            state_next.fst      = F_IDLE;
            state_next.busy     = 1'b0;
            state_next.done     = 1'b1;
            state_next.pf_addr  = state_reg.addr + ADDR_W'(1); // R12
            state_next.pf_left  = penalty;
            state_next.pf_valid = 1'b1;
          end
        end
      end
      default:
      begin
        state_next     = '0;
        state_next.fst = F_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_reg     <= '0;
      state_reg.fst <= F_IDLE;
    end
    else
      state_reg <= state_next;
  end

  assign access_busy  = state_reg.busy;
  assign access_done  = state_reg.done;
  assign prefetch_hit = state_reg.hit;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [CNT_W:0] chk_ticks;
  logic [CNT_W:0] chk_exp;

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      chk_ticks <= '0;
      chk_exp   <= '0;
    end
    else if (state_reg.fst == F_IDLE && access_req)
    begin
      chk_ticks <= '0;
      chk_exp   <= (CNT_W+1)'(flash_wait_state_count) + (CNT_W+1)'(flash_wait_extension)
                   + (CNT_W+1)'(1);
    end
    else if (state_reg.busy && sys_tick)
      chk_ticks <= chk_ticks + (CNT_W+1)'(1);
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  chk_full_penalty: assert property ( // R9 R10 R11
    access_done && !prefetch_hit |-> chk_ticks == chk_exp)
    else $error("non-sequential access wait count wrong");
  chk_prefetch_gain: assert property ( // R12
    access_done && prefetch_hit |-> chk_ticks <= chk_exp && chk_ticks != '0)
    else $error("prefetch hit took longer than full penalty");
  chk_done_pulse: assert property ( // R11
    access_done |-> !access_busy ##1 !access_done)
    else $error("done not a single cycle pulse");
  cov_seq_hit: cover property (access_done && prefetch_hit && chk_ticks < chk_exp);

endmodule

// File: testbench/osc_model.sv
// free-running clock source model for the system clock selector inputs
`timescale 1ns/1ps
module osc_model #(
  parameter int OFS_NS = 1
)(
  input  int   hi_ns,
  input  int   lo_ns,
  output logic clk
);
  // odd offset keeps source edges away from reference edges, so sampling is exact
  initial
  begin
    clk = 1'b0;
    #(OFS_NS);
    forever
    begin
      clk = 1'b1;
      #(hi_ns);
      clk = 1'b0;
      #(lo_ns);
    end
  end
endmodule

// File: testbench/sysclk_source_prescaler_tb_top.sv
// self-checking bench for clock source selection, prescaler and flash wait timing
`timescale 1ns/1ps
module sysclk_source_prescaler_tb_top;
  import sysclk_pkg::*;

  localparam int BOUND = 12000;

  logic                  ref_clk;
  logic                  reset_n;
  logic [4:0]            src;
  logic [1:0]            clock_source_select;
  logic                  oscillator_bypass;
  logic                  prescaler_source_select;
  logic [DIV_FIELD_W-1:0] prescaler_divider_field;
  logic [WS_W-1:0]       flash_wait_state_count;
  logic [EXT_W-1:0]      flash_wait_extension;
  logic                  access_req;
  logic                  access_seq;
  logic [ADDR_W_DEF-1:0] access_addr;
  logic                  sys_clock;
  logic                  sys_tick;
  mode_type              active_mode;
  logic                  switch_busy;
  logic                  access_busy;
  logic                  access_done;
  logic                  prefetch_hit;
  logic                  last_clk;
  logic                  seen_rise;
  logic [31:0]           rng;
  logic [ADDR_W_DEF-1:0] addr;
  int                    bad_count;
  int                    compares;
  int                    since_tick;
  int                    run_len;
  int                    exp_high;
  int                    flash_ticks;
  int                    k;
  int                    period_q[$];
  int                    flash_q[$];
  int                    hi_ns[5] = '{12, 16, 24, 16, 40};
  int                    lo_ns[5] = '{28, 24, 24, 16, 40};

  osc_model #(.OFS_NS(1)) i_osc_model_direct (.hi_ns(hi_ns[0]), .lo_ns(lo_ns[0]), .clk(src[0]));
  osc_model #(.OFS_NS(3)) i_osc_model_crystal (.hi_ns(hi_ns[1]), .lo_ns(lo_ns[1]), .clk(src[1]));
  osc_model #(.OFS_NS(5)) i_osc_model_internal (.hi_ns(hi_ns[2]), .lo_ns(lo_ns[2]), .clk(src[2]));
  osc_model #(.OFS_NS(7)) i_osc_model_loop (.hi_ns(hi_ns[3]), .lo_ns(lo_ns[3]), .clk(src[3]));
  osc_model #(.OFS_NS(9)) i_osc_model_wakeup (.hi_ns(hi_ns[4]), .lo_ns(lo_ns[4]), .clk(src[4]));

  sysclk_source_prescaler i_sysclk_source_prescaler (
    .ref_clk                 (ref_clk),
    .reset_n                 (reset_n),
    .direct_clock_input      (src[0]),
    .crystal_input           (src[1]),
    .internal_osc_input      (src[2]),
    .loop_clock_input        (src[3]),
    .wakeup_osc_input        (src[4]),
    .clock_source_select     (clock_source_select),
    .oscillator_bypass       (oscillator_bypass),
    .prescaler_source_select (prescaler_source_select),
    .prescaler_divider_field (prescaler_divider_field),
    .flash_wait_state_count  (flash_wait_state_count),
    .flash_wait_extension    (flash_wait_extension),
    .access_req              (access_req),
    .access_seq              (access_seq),
    .access_addr             (access_addr),
    .sys_clock               (sys_clock),
    .sys_tick                (sys_tick),
    .active_mode             (active_mode),
    .switch_busy             (switch_busy),
    .access_busy             (access_busy),
    .access_done             (access_done),
    .prefetch_hit            (prefetch_hit)
  );

  initial ref_clk = 1'b0;
  always #2 ref_clk = ~ref_clk;

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic give_up(input string what);
    bad_count++;
    $display("ERROR %s expected progress seen timeout", what);
    tally_and_finish();
  endtask

  task automatic wait_ticks(input int n);
    int seen;
    int w;
    seen = 0;
    w = 0;
    while (seen < n && w < BOUND * n)
    begin
      @(negedge ref_clk);
      w++;
      if (sys_tick === 1'b1)
        seen++;
    end
    if (seen < n)
      give_up("sys_tick");
  endtask

  task automatic wait_drain(input string what, input int which);
    int w;
    w = 0;
    while ((which == 0 ? period_q.size() : flash_q.size()) > 0 && w < BOUND)
    begin
      @(negedge ref_clk);
      w++;
    end
    if (w >= BOUND)
      give_up(what);
  endtask

  task automatic set_clock(input logic [1:0] sel, input logic byp, input logic osc, input int f);
    int w;
    exp_high = 0;
    clock_source_select = sel;
    oscillator_bypass = byp;
    prescaler_source_select = osc;
    prescaler_divider_field = DIV_FIELD_W'(f - 1);
    w = 0;
    repeat (3) @(negedge ref_clk);
    while (switch_busy !== 1'b0 && w < BOUND)
    begin
      @(negedge ref_clk);
      w++;
    end
    if (switch_busy !== 1'b0)
      give_up("switch_busy");
    wait_ticks(2);
  endtask

  task automatic expect_clock(input string name, input mode_type m, input int per, input int hi);
    check({name, " mode"}, 32'(m), 32'(active_mode));
    exp_high = hi;
    period_q.push_back(per);
    wait_drain(name, 0);
    $display("test %s done", name);
  endtask

  task automatic flash_access(input logic seq, input logic [ADDR_W_DEF-1:0] a, input int t,
                              input int hit);
    int w;
    flash_q.push_back(t * 2 + hit);
    access_req = 1'b1;
    access_seq = seq;
    access_addr = a;
    w = 0;
    do
    begin
      @(negedge ref_clk);
      w++;
    end
    while (access_busy !== 1'b1 && w < BOUND);
    if (access_busy !== 1'b1)
      give_up("access_busy");
    access_req = 1'b0;
    access_seq = ~seq;
    access_addr = ~a;
    wait_drain("access_done", 1);
  endtask

  // ----------------------------------------------------------------
  // monitors: period, phase length, flash latency
  // ----------------------------------------------------------------
  always @(negedge ref_clk)
  begin
    since_tick++;
    if (sys_tick === 1'b1)
    begin
      if (period_q.size() > 0)
        check("tick period", period_q.pop_front(), since_tick);
      since_tick = 0;
    end
    if (sys_clock !== last_clk)
    begin
      if (seen_rise)
        check("phase at least three", 1, 32'(run_len >= 3));
      if (last_clk === 1'b1 && exp_high > 0)
        check("high time", exp_high, run_len);
      if (sys_clock === 1'b1)
        seen_rise = 1'b1;
      run_len = 0;
    end
    run_len++;
    last_clk = sys_clock;
    if (access_busy === 1'b1 && sys_tick === 1'b1)
      flash_ticks++;
    if (access_done === 1'b1)
    begin
      if (flash_q.size() > 0)
        check("flash ticks and hit", flash_q.pop_front(),
              32'(flash_ticks * 2) | {31'h0, prefetch_hit});
      else
        check("unexpected done", 0, 1);
      flash_ticks = 0;
    end
  end

  initial
  begin
    reset_n = 1'b0;
    clock_source_select = SEL_DIRECT;
    oscillator_bypass = 1'b0;
    prescaler_source_select = 1'b0;
    prescaler_divider_field = '0;
    flash_wait_state_count = 4'h4;
    flash_wait_extension = 2'h0;
    access_req = 1'b0;
    access_seq = 1'b0;
    access_addr = '0;
    rng = 32'hAEC485FF;
    last_clk = 1'b0;
    seen_rise = 1'b0;
    bad_count = 0;
    compares = 0;
    since_tick = 0;
    run_len = 0;
    exp_high = 0;
    flash_ticks = 0;
    repeat (12) @(posedge ref_clk);
    @(negedge ref_clk);
    reset_n = 1'b1;
    wait_ticks(2);
    expect_clock("direct", MODE_DIRECT, 10, 3);
    // software side may program any count; low values exercise the device path
    for (int ws = 1; ws <= 4; ws++)
      for (int ext = 0; ext <= 1; ext++)
      begin
        flash_wait_state_count = WS_W'(ws);
        flash_wait_extension = EXT_W'(ext);
        rng = xorshift(rng);
        flash_access(1'b0, {1'b0, rng[ADDR_W_DEF-2:0]}, ws + ext + 1, 0);
      end
    flash_wait_state_count = 4'h2;
    flash_wait_extension = 2'h1;
    addr = {1'b0, rng[ADDR_W_DEF-2:1], 1'b0};
    flash_access(1'b0, addr, 4, 0);
    wait_ticks(6);
    flash_access(1'b1, addr + 1'b1, 1, 1);
    flash_access(1'b1, addr + 20'h7, 4, 0);
    $display("test flash wait states done");
    set_clock(SEL_PRESCALE, 1'b1, 1'b0, 1);
    expect_clock("crystal factor one", MODE_PRESCALE, 10, 4);
    rng = xorshift(rng);
    k = int'(rng[2:0]) + 2;
    set_clock(SEL_PRESCALE, 1'b1, 1'b1, k);
    expect_clock("internal divided", MODE_PRESCALE, 12 * k, 12 * ((k + 1) / 2));
    set_clock(SEL_PRESCALE, 1'b0, 1'b0, 1);
    expect_clock("loop", MODE_LOOP, 8, 4);
    set_clock(SEL_WAKEUP, 1'b0, 1'b0, 1);
    expect_clock("wakeup", MODE_WAKEUP, 20, 10);
    clock_source_select = SEL_RESERVED;
    repeat (20) @(negedge ref_clk);
    check("reserved keeps mode", 32'(MODE_WAKEUP), 32'(active_mode));
    check("reserved no switch", 0, 32'(switch_busy));
    $display("test reserved select done");
    set_clock(SEL_PRESCALE, 1'b1, 1'b0, MAX_PRESCALE);
    expect_clock("largest factor", MODE_PRESCALE, 10 * MAX_PRESCALE, 5 * MAX_PRESCALE);
    tally_and_finish();
  end
endmodule
